/* File: core/efbsc_top.sv */
// The AXI4-Lite register port is this design's own decision.
`timescale 1ns/1ps
// E1 far-end block error and receive slip monitor counters, AXI4-Lite slave
module efbsc_top (
   // Clock and reset
   input wire logic sys_clk_in,
   input wire logic rstn_in,
   // Framer events
   input wire logic ebit_zero_in,
   input wire logic fas_sync_lost_in,
   input wire logic crc4_mf_sync_lost_in,
   input wire logic cas_mf_sync_lost_in,
   input wire logic slip_repeat_in,
   input wire logic slip_delete_in,
   // AXI4-Lite write address
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [efbsc_pkg::AXI_ADDR_W-1:0] s_axi_awaddr,
   input wire logic [2:0] s_axi_awprot,
   // AXI4-Lite write data
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   input wire logic [efbsc_pkg::AXI_DATA_W-1:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   // AXI4-Lite write response
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   output logic [1:0] s_axi_bresp,
   // AXI4-Lite read address
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   input wire logic [efbsc_pkg::AXI_ADDR_W-1:0] s_axi_araddr,
   input wire logic [2:0] s_axi_arprot,
   // AXI4-Lite read data
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output logic [efbsc_pkg::AXI_DATA_W-1:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   // Interrupt
   output logic irq_out
);
   import efbsc_pkg::*;

   logic rst_n; // Synchronised reset for the whole block

   // Reset release
   efbsc_rst_sync u_rst_sync (
      .clk_in(sys_clk_in),
      .rstn_in(rstn_in),
      .rstn_out(rst_n)
   );

   // Event qualification
   logic fe_inc; // Qualified far-end block error
   logic slip_inc; // One frame repeated or dropped

   // CAS multiframe loss deliberately plays no part here
   assign fe_inc = ebit_zero_in && !fas_sync_lost_in
      && !crc4_mf_sync_lost_in;
   assign slip_inc = slip_repeat_in || slip_delete_in;

   // Read channel decode
   logic rd_take; // Read address accepted this cycle
   logic [REG_IDX_W-1:0] rd_idx; // Register index being read
   logic rd_hi; // Upper byte read accepted
   logic rd_lo; // Lower byte read accepted
   logic rd_slip; // Slip count read accepted

   assign rd_take = s_axi_arvalid && s_axi_arready;
   assign rd_idx = s_axi_araddr[AXI_ADDR_W-1:2];
   assign rd_hi = rd_take && (rd_idx == IDX_FE_HI);
   assign rd_lo = rd_take && (rd_idx == IDX_FE_LO);
   assign rd_slip = rd_take && (rd_idx == IDX_SLIP);

   // Counters
   logic [FE_CNT_W-1:0] fe_cnt; // Far-end block error count
   logic [SLIP_CNT_W-1:0] slip_cnt; // Receive slip count
   logic [BYTE_W-1:0] fe_lo_hold; // Lower byte captured at upper read

   // Upper read clears the whole count; the low byte lives on in the hold
   efbsc_counter #(
      .W(FE_CNT_W)
   ) u_fe_cnt (
      .clk_in(sys_clk_in),
      .rstn_in(rst_n),
      .inc_in(fe_inc),
      .clr_in(rd_hi),
      .count_out(fe_cnt)
   );

   efbsc_counter #(
      .W(SLIP_CNT_W)
   ) u_slip_cnt (
      .clk_in(sys_clk_in),
      .rstn_in(rst_n),
      .inc_in(slip_inc),
      .clr_in(rd_slip),
      .count_out(slip_cnt)
   );

   // Lower byte snapshot; a lone low read returns it and empties it
   always_ff @(posedge sys_clk_in or negedge rst_n) begin
      if (!rst_n) begin
         fe_lo_hold <= '0;
      end else if (rd_hi) begin
         fe_lo_hold <= fe_cnt[BYTE_W-1:0];
      end else if (rd_lo) begin
         fe_lo_hold <= '0;
      end
   end

   // Interrupt registers
   logic [STAT_W-1:0] irq_status; // Sticky event bits
   logic [STAT_W-1:0] irq_enable; // Mask onto irq_out
   logic [STAT_W-1:0] stat_set; // Events this cycle
   logic [STAT_W-1:0] stat_clr; // Software clear this cycle
   logic irq_any; // Some enabled status bit is set

   assign irq_any = |(irq_status & irq_enable);

   assign stat_set[STAT_FE_BIT] = fe_inc;
   assign stat_set[STAT_SLIP_BIT] = slip_inc;

   // Write channel state
   logic aw_got; // Write address held
   logic w_got; // Write data held
   logic [REG_IDX_W-1:0] wr_idx; // Held write index
   logic [AXI_DATA_W-1:0] wr_data; // Held write data
   logic [3:0] wr_strb; // Held byte strobes
   logic wr_do; // Both halves present, perform the write
   logic wr_mapped; // Index is a writable register

   assign wr_do = aw_got && w_got && !s_axi_bvalid;
   assign wr_mapped = (wr_idx == IDX_IRQ_ENABLE) || (wr_idx == IDX_IRQ_CLEAR);
   assign stat_clr = (wr_do && wr_idx == IDX_IRQ_CLEAR && wr_strb[0])
      ? wr_data[STAT_W-1:0] : '0;

   // Sticky status; a new event beats a clear in the same cycle
   always_ff @(posedge sys_clk_in or negedge rst_n) begin
      if (!rst_n) begin
         irq_status <= STAT_RST;
      end else begin
         irq_status <= (irq_status & ~stat_clr) | stat_set;
      end
   end

   // Enable register
   always_ff @(posedge sys_clk_in or negedge rst_n) begin
      if (!rst_n) begin
         irq_enable <= STAT_RST;
      end else if (wr_do && wr_idx == IDX_IRQ_ENABLE && wr_strb[0]) begin
         irq_enable <= wr_data[STAT_W-1:0];
      end
   end

   // Registered interrupt level, one cycle behind status
   always_ff @(posedge sys_clk_in or negedge rst_n) begin
      if (!rst_n) begin
         irq_out <= 1'b0;
      end else begin
         irq_out <= irq_any;
      end
   end

   // Address and data may arrive in either order; each is held until B
   always_ff @(posedge sys_clk_in or negedge rst_n) begin
      if (!rst_n) begin
         aw_got <= 1'b0;
         s_axi_awready <= 1'b0;
         wr_idx <= '0;
      end else if (s_axi_awvalid && s_axi_awready) begin
         aw_got <= 1'b1;
         s_axi_awready <= 1'b0;
         wr_idx <= s_axi_awaddr[AXI_ADDR_W-1:2];
      end else if (s_axi_bvalid && s_axi_bready) begin
         aw_got <= 1'b0;
         s_axi_awready <= 1'b1;
      end else if (!aw_got) begin
         s_axi_awready <= 1'b1;
      end
   end

   // Write data capture
   always_ff @(posedge sys_clk_in or negedge rst_n) begin
      if (!rst_n) begin
         w_got <= 1'b0;
         s_axi_wready <= 1'b0;
         wr_data <= RDATA_RST;
         wr_strb <= 4'h0;
      end else if (s_axi_wvalid && s_axi_wready) begin
         w_got <= 1'b1;
         s_axi_wready <= 1'b0;
         wr_data <= s_axi_wdata;
         wr_strb <= s_axi_wstrb;
      end else if (s_axi_bvalid && s_axi_bready) begin
         w_got <= 1'b0;
         s_axi_wready <= 1'b1;
      end else if (!w_got) begin
         s_axi_wready <= 1'b1;
      end
   end

   // Write response; counters and status are read-only and refuse writes
   always_ff @(posedge sys_clk_in or negedge rst_n) begin
      if (!rst_n) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= RESP_OKAY;
      end else if (wr_do) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // Read data select, valued at the accepting edge
   logic [AXI_DATA_W-1:0] next_rdata; // Word for the read answer
   logic [1:0] next_rresp; // Response for the read answer

   always_comb begin
      next_rdata = RDATA_RST;
      next_rresp = RESP_OKAY;
      case (rd_idx)
         IDX_FE_HI: begin
            next_rdata[BYTE_W-1:0] = fe_cnt[FE_CNT_W-1:BYTE_W];
         end
         IDX_FE_LO: begin
            next_rdata[BYTE_W-1:0] = fe_lo_hold;
         end
         IDX_SLIP: begin
            next_rdata[SLIP_CNT_W-1:0] = slip_cnt;
         end
         IDX_IRQ_STATUS: begin
            next_rdata[STAT_W-1:0] = irq_status;
         end
         IDX_IRQ_ENABLE: begin
            next_rdata[STAT_W-1:0] = irq_enable;
         end
         IDX_IRQ_CLEAR: begin
            next_rdata = RDATA_RST; // Write-only, reads zero
         end
         default: begin
            next_rresp = RESP_SLVERR; // Unmapped address
         end
      endcase
   end

   // Read channel; one read in flight, arready drops until R is taken
   always_ff @(posedge sys_clk_in or negedge rst_n) begin
      if (!rst_n) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= RDATA_RST;
         s_axi_rresp <= RESP_OKAY;
      end else if (rd_take) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= next_rdata;
         s_axi_rresp <= next_rresp;
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
         s_axi_arready <= 1'b1;
      end else if (!s_axi_rvalid) begin
         s_axi_arready <= 1'b1;
      end
   end

   // Checks on the counters, their bus view and the interrupt level
   default clocking cb @(posedge sys_clk_in);
   endclocking
   default disable iff (!rst_n);

   property p_fe_count;
      (fe_inc && !rd_hi && fe_cnt != 16'hFFFF) |=> fe_cnt == $past(fe_cnt) + 16'h0001;
   endproperty
   a_fe_count: assert property (p_fe_count)
      else $error("far-end count missed an E-bit");

   property p_fe_sync_hold;
      ((fas_sync_lost_in || crc4_mf_sync_lost_in) && !rd_hi) |=> $stable(fe_cnt);
   endproperty
   a_fe_sync_hold: assert property (p_fe_sync_hold)
      else $error("far-end count moved during sync loss");

   property p_fe_cas_counts;
      (ebit_zero_in && cas_mf_sync_lost_in && !fas_sync_lost_in && !crc4_mf_sync_lost_in
         && !rd_hi && fe_cnt != 16'hFFFF) |=> fe_cnt == $past(fe_cnt) + 16'h0001;
   endproperty
   a_fe_cas_counts: assert property (p_fe_cas_counts)
      else $error("far-end count stopped on CAS loss");

   property p_fe_clear;
      rd_hi |=> fe_cnt == ($past(fe_inc) ? 16'h0001 : 16'h0000);
   endproperty
   a_fe_clear: assert property (p_fe_clear)
      else $error("far-end count not cleared by read");

   property p_hold_snap;
      rd_hi |=> fe_lo_hold == $past(fe_cnt[7:0]) ##0 s_axi_rvalid
         ##0 s_axi_rdata == {24'h00_0000, $past(fe_cnt[15:8])};
   endproperty
   a_hold_snap: assert property (p_hold_snap)
      else $error("upper read answer or low snapshot wrong");

   property p_lo_read;
      rd_lo |=> s_axi_rdata == {24'h00_0000, $past(fe_lo_hold)} ##0 fe_lo_hold == 8'h00;
   endproperty
   a_lo_read: assert property (p_lo_read)
      else $error("lower read did not return snapshot");

   property p_slip_count;
      (slip_inc && !rd_slip && slip_cnt != 8'hFF) |=> slip_cnt == $past(slip_cnt) + 8'h01;
   endproperty
   a_slip_count: assert property (p_slip_count)
      else $error("slip count missed an event");

   property p_slip_clear;
      rd_slip |=> slip_cnt == ($past(slip_inc) ? 8'h01 : 8'h00)
         ##0 s_axi_rdata == {24'h00_0000, $past(slip_cnt)};
   endproperty
   a_slip_clear: assert property (p_slip_clear)
      else $error("slip read answer or clear wrong");

   property p_reset_zero;
      $rose(rst_n) |-> fe_cnt == 16'h0000 && slip_cnt == 8'h00 && fe_lo_hold == 8'h00;
   endproperty
   a_reset_zero: assert property (p_reset_zero)
      else $error("counter not zero after reset");

   property p_irq_level;
      1'b1 |=> irq_out == $past(irq_any);
   endproperty
   a_irq_level: assert property (p_irq_level)
      else $error("interrupt level does not follow status");
endmodule : efbsc_top

/* File: core/efbsc_pkg.sv */
// Notes on behaviour
// - Far-end block error count is 16 bits, split bytes
// - Low byte register returns bits seven to zero
// - Count one per received E-bit at zero
// - No counting during FAS or CRC-4 sync loss
// - CAS multiframe sync loss does not stop counting
// - Reading a counter returns it, then clears it
// - Counts cover events since that counter's last read
// - Eight-bit clear-on-read receive slip counter
// - One slip per frame repeated or dropped
package efbsc_pkg;
   // Bus geometry
   localparam int AXI_ADDR_W = 16;
   localparam int AXI_DATA_W = 32;
   localparam int REG_IDX_W = 14;

   // Register indices; byte address is four times the index
   localparam logic [13:0] IDX_FE_HI = 14'h0907;
   localparam logic [13:0] IDX_FE_LO = 14'h0908;
   localparam logic [13:0] IDX_SLIP = 14'h0909;
   localparam logic [13:0] IDX_IRQ_STATUS = 14'h0910;
   localparam logic [13:0] IDX_IRQ_ENABLE = 14'h0911;
   localparam logic [13:0] IDX_IRQ_CLEAR = 14'h0912;

   // Counter widths
   localparam int FE_CNT_W = 16;
   localparam int SLIP_CNT_W = 8;
   localparam int BYTE_W = 8;

   // Reset values
   localparam logic [15:0] FE_CNT_RST = 16'h0000;
   localparam logic [7:0] SLIP_CNT_RST = 8'h00;
   localparam logic [31:0] RDATA_RST = 32'h0000_0000;

   // Interrupt status layout
   localparam int STAT_W = 2;
   localparam int STAT_FE_BIT = 0;
   localparam int STAT_SLIP_BIT = 1;
   localparam logic [1:0] STAT_RST = 2'h0;

   // AXI response codes
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : efbsc_pkg

/* File: core/efbsc_rst_sync.sv */
`timescale 1ns/1ps
// Two-stage reset release; assertion is immediate, release is clocked
module efbsc_rst_sync (
   // Clock and raw reset
   input wire logic clk_in,
   input wire logic rstn_in,
   // Synchronised reset
   output logic rstn_out
);
   logic stage1; // First stage, read only by the second

   // Release through two flops so deassertion meets timing
   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         stage1 <= 1'b0;
         rstn_out <= 1'b0;
      end else begin
         stage1 <= 1'b1;
         rstn_out <= stage1;
      end
   end
endmodule : efbsc_rst_sync

/* File: core/efbsc_counter.sv */
`timescale 1ns/1ps
// Saturating clear-on-read event counter
module efbsc_counter #(
   parameter int W = 8
) (
   // Clock and reset
   input wire logic clk_in,
   input wire logic rstn_in,
   // Event and clear
   input wire logic inc_in,
   input wire logic clr_in,
   // Current count
   output logic [W-1:0] count_out
);
   // Refuse widths the bus cannot present
   if (W < 1 || W > 32) begin : g_bad_w
      $error("efbsc_counter width out of range");
   end

   logic [W-1:0] next_count; // Value for the next edge
   logic at_max; // Saturated; wrapping would fake a small count

   assign at_max = &count_out;

   // An event in the clearing cycle starts the new interval at one
   always_comb begin
      next_count = count_out;
      if (clr_in) begin
         next_count = inc_in ? W'(1) : '0;
      end else if (inc_in && !at_max) begin
         next_count = count_out + W'(1);
      end
   end

   // Count register, zero after reset
   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         count_out <= '0;
      end else begin
         count_out <= next_count;
      end
   end
endmodule : efbsc_counter

/* File: testbench/efbsc_host_model.sv */
`timescale 1ns/1ps
// Host processor model: AXI4-Lite master, one read and one write at a time
module efbsc_host_model (
   // Clock
   input wire logic clk_in,
   // Write address and data
   output logic awvalid_out,
   input wire logic awready_in,
   output logic [efbsc_pkg::AXI_ADDR_W-1:0] awaddr_out,
   output logic wvalid_out,
   input wire logic wready_in,
   output logic [efbsc_pkg::AXI_DATA_W-1:0] wdata_out,
   // Write response
   input wire logic bvalid_in,
   output logic bready_out,
   input wire logic [1:0] bresp_in,
   // Read address
   output logic arvalid_out,
   input wire logic arready_in,
   output logic [efbsc_pkg::AXI_ADDR_W-1:0] araddr_out,
   // Read data
   input wire logic rvalid_in,
   output logic rready_out,
   input wire logic [efbsc_pkg::AXI_DATA_W-1:0] rdata_in,
   input wire logic [1:0] rresp_in
);
   import efbsc_pkg::*;
   // Response ready held high so a task never toggles it twice in one step
   initial begin
      {awvalid_out, wvalid_out, arvalid_out} = 3'h0;
      {awaddr_out, araddr_out, wdata_out} = '0;
      rready_out = 1'b1;
      bready_out = 1'b1;
   end
   // One read; valid and address stay put until arready is sampled
   task automatic rd(input logic [13:0] idx, output logic [31:0] data,
                     output logic [1:0] resp);
      arvalid_out <= 1'b1;
      araddr_out <= {idx, 2'b00};
      do @(posedge clk_in); while (arready_in !== 1'b1);
      arvalid_out <= 1'b0;
      while (rvalid_in !== 1'b1) @(posedge clk_in);
      data = rdata_in;
      resp = rresp_in;
   endtask : rd
   // One write; address and data released each at its own handshake
   task automatic wr(input logic [13:0] idx, input logic [31:0] data,
                     output logic [1:0] resp);
      logic aw_p;
      logic w_p;
      aw_p = 1'b1;
      w_p = 1'b1;
      awvalid_out <= 1'b1;
      awaddr_out <= {idx, 2'b00};
      wvalid_out <= 1'b1;
      wdata_out <= data;
      while (aw_p || w_p) begin
         @(posedge clk_in);
         if (aw_p && awready_in === 1'b1) begin
            aw_p = 1'b0;
            awvalid_out <= 1'b0;
         end
         if (w_p && wready_in === 1'b1) begin
            w_p = 1'b0;
            wvalid_out <= 1'b0;
         end
      end
      while (bvalid_in !== 1'b1) @(posedge clk_in);
      resp = bresp_in;
   endtask : wr
   // Sixteen-bit count: upper byte first, lower byte after it
   task automatic fe_read(output logic [15:0] cnt);
      logic [31:0] hi;
      logic [31:0] lo;
      logic [1:0] rs;
      rd(IDX_FE_HI, hi, rs);
      rd(IDX_FE_LO, lo, rs);
      cnt = {hi[7:0], lo[7:0]};
   endtask : fe_read
endmodule : efbsc_host_model

/* File: testbench/efbsc_bench.sv */
`timescale 1ns/1ps
// Self-checking bench for the monitor counters
module efbsc_bench;
   import efbsc_pkg::*;
   logic sys_clk_in, rstn_in, irq_out;
   logic fas_sync_lost_in, crc4_mf_sync_lost_in, cas_mf_sync_lost_in;
   logic [2:0] ev; // Pulses: bit0 E-bit zero, bit1 repeat, bit2 delete
   logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
   logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   logic [AXI_ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
   logic [AXI_DATA_W-1:0] s_axi_wdata, s_axi_rdata;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   int err_total = 0;
   int checks_done = 0;
   int cycles = 0;
   logic [31:0] d;
   logic [1:0] r;
   logic [15:0] c;
   // Device under test; protection and strobes tied to plain full-word access
   efbsc_top DUT (.sys_clk_in, .rstn_in, .ebit_zero_in(ev[0]), .fas_sync_lost_in,
      .crc4_mf_sync_lost_in, .cas_mf_sync_lost_in, .slip_repeat_in(ev[1]),
      .slip_delete_in(ev[2]), .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr,
      .s_axi_awprot(3'h0), .s_axi_wvalid, .s_axi_wready, .s_axi_wdata,
      .s_axi_wstrb(4'hF), .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid,
      .s_axi_arready, .s_axi_araddr, .s_axi_arprot(3'h0), .s_axi_rvalid,
      .s_axi_rready, .s_axi_rdata, .s_axi_rresp, .irq_out);
   // Host on the register bus
   efbsc_host_model host (.clk_in(sys_clk_in), .awvalid_out(s_axi_awvalid),
      .awready_in(s_axi_awready), .awaddr_out(s_axi_awaddr), .wvalid_out(s_axi_wvalid),
      .wready_in(s_axi_wready), .wdata_out(s_axi_wdata), .bvalid_in(s_axi_bvalid),
      .bready_out(s_axi_bready), .bresp_in(s_axi_bresp), .arvalid_out(s_axi_arvalid),
      .arready_in(s_axi_arready), .araddr_out(s_axi_araddr), .rvalid_in(s_axi_rvalid),
      .rready_out(s_axi_rready), .rdata_in(s_axi_rdata), .rresp_in(s_axi_rresp));
   // 40 MHz clock
   initial begin
      sys_clk_in = 1'b0;
      forever #12.5 sys_clk_in = ~sys_clk_in;
   end
   // Compare and count
   task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string m);
      checks_done++;
      if (seen !== exp) begin
         err_total++;
         $display("MISMATCH at %0t: %s seen %h expected %h", $time, m, seen, exp);
      end
   endtask : check
   // Hold a pulse pattern for n cycles, then let the counts settle
   task automatic pulse(input logic [2:0] pat, input int n);
      ev <= pat;
      repeat (n) @(posedge sys_clk_in);
      ev <= 3'h0;
      repeat (3) @(posedge sys_clk_in);
   endtask : pulse
   // Counters come out of reset at zero
   task automatic t_reset;
      host.rd(IDX_FE_HI, d, r);
      check(d, 32'h0000_0000, "upper after reset");
      host.rd(IDX_FE_LO, d, r);
      check(d, 32'h0000_0000, "lower after reset");
      host.rd(IDX_SLIP, d, r);
      check(d, 32'h0000_0000, "slip after reset");
      check(32'(irq_out), 32'h0000_0000, "irq after reset");
      $display("t_reset done");
   endtask : t_reset
   // 300 events carry into the upper byte; a second read shows the clear
   task automatic t_fe_count;
      pulse(3'h1, 300);
      host.fe_read(c);
      check(32'(c), 32'h0000_012C, "fe count 300");
      host.fe_read(c);
      check(32'(c), 32'h0000_0000, "fe cleared");
      $display("t_fe_count done");
   endtask : t_fe_count
   // FAS and CRC-4 loss stop counting, CAS loss does not
   task automatic t_gating;
      fas_sync_lost_in <= 1'b1;
      pulse(3'h1, 3);
      fas_sync_lost_in <= 1'b0;
      crc4_mf_sync_lost_in <= 1'b1;
      pulse(3'h1, 4);
      crc4_mf_sync_lost_in <= 1'b0;
      cas_mf_sync_lost_in <= 1'b1;
      pulse(3'h1, 5);
      cas_mf_sync_lost_in <= 1'b0;
      host.fe_read(c);
      check(32'(c), 32'h0000_0005, "fe gated");
      $display("t_gating done");
   endtask : t_gating
   // Events between the two byte reads land in the next count, not the hold
   task automatic t_split;
      pulse(3'h1, 2);
      host.rd(IDX_FE_HI, d, r);
      check(d, 32'h0000_0000, "upper of 2");
      pulse(3'h1, 3);
      host.rd(IDX_FE_LO, d, r);
      check(d, 32'h0000_0002, "held lower");
      host.fe_read(c);
      check(32'(c), 32'h0000_0003, "since last read");
      $display("t_split done");
   endtask : t_split
   // Repeats, deletes and both at once; then saturation at eight bits
   task automatic t_slip;
      pulse(3'h2, 4);
      pulse(3'h4, 3);
      pulse(3'h6, 2);
      host.rd(IDX_SLIP, d, r);
      check(d, 32'h0000_0009, "slip count");
      host.rd(IDX_SLIP, d, r);
      check(d, 32'h0000_0000, "slip cleared");
      pulse(3'h2, 260);
      host.rd(IDX_SLIP, d, r);
      check(d, 32'h0000_00FF, "slip saturates");
      $display("t_slip done");
   endtask : t_slip
   // Interrupt raised, cleared, masked, then released by enable
   task automatic t_irq;
      // Earlier tests left both sticky bits set; start from a clean status
      host.wr(IDX_IRQ_CLEAR, 32'h0000_0003, r);
      host.wr(IDX_IRQ_ENABLE, 32'h0000_0001, r);
      check(32'(r), 32'(RESP_OKAY), "enable write");
      host.rd(IDX_IRQ_ENABLE, d, r);
      check(d, 32'h0000_0001, "enable readback");
      check(32'(irq_out), 32'h0000_0000, "irq quiet before event");
      pulse(3'h1, 1);
      check(32'(irq_out), 32'h0000_0001, "irq raised");
      host.rd(IDX_IRQ_STATUS, d, r);
      check(d, 32'h0000_0001, "status fe");
      host.wr(IDX_IRQ_CLEAR, 32'h0000_0001, r);
      repeat (2) @(posedge sys_clk_in);
      check(32'(irq_out), 32'h0000_0000, "irq cleared");
      pulse(3'h2, 1);
      check(32'(irq_out), 32'h0000_0000, "irq masked");
      host.rd(IDX_IRQ_STATUS, d, r);
      check(d, 32'h0000_0002, "status slip");
      host.wr(IDX_IRQ_ENABLE, 32'h0000_0003, r);
      repeat (2) @(posedge sys_clk_in);
      check(32'(irq_out), 32'h0000_0001, "irq unmasked");
      host.wr(IDX_IRQ_CLEAR, 32'h0000_0003, r);
      host.fe_read(c);
      check(32'(c), 32'h0000_0001, "fe one");
      $display("t_irq done");
   endtask : t_irq
   // Unmapped read and write to a read-clear counter are refused
   task automatic t_refuse;
      host.rd(14'h0000, d, r);
      check(32'(r), 32'(RESP_SLVERR), "unmapped read");
      check(d, 32'h0000_0000, "unmapped data");
      host.wr(IDX_SLIP, 32'h0000_00AA, r);
      check(32'(r), 32'(RESP_SLVERR), "write to counter");
      host.rd(IDX_SLIP, d, r);
      check(d, 32'h0000_0001, "slip untouched by write");
      $display("t_refuse done");
   endtask : t_refuse
   // Counts and the verdict
   task automatic print_verdict;
      $display("Counts: %0d comparisons, %0d mismatches", checks_done, err_total);
      if (err_total == 0 && checks_done > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : print_verdict
   // Hang guard; the tests need well under 3000 cycles
   always @(posedge sys_clk_in) begin
      cycles++;
      if (cycles == 20000) begin
         err_total++;
         print_verdict();
      end
   end
   // Main sequence
   initial begin
      ev = 3'h0;
      {fas_sync_lost_in, crc4_mf_sync_lost_in, cas_mf_sync_lost_in} = 3'h0;
      rstn_in = 1'b0;
      repeat (20) @(posedge sys_clk_in);
      rstn_in <= 1'b1;
      repeat (4) @(posedge sys_clk_in);
      t_reset();
      t_fe_count();
      t_gating();
      t_split();
      t_slip();
      t_irq();
      t_refuse();
      print_verdict();
   end
endmodule : efbsc_bench
